/* include/loc_pkg.sv */
package loc_pkg;

   // system clock and millisecond time base
   localparam int CLK_PERIOD_NS    = 10;
   localparam int TICK_MS          = 1;
   localparam int NS_PER_MS        = 1000000;
   localparam int TICK_CYCLES_DFLT = (TICK_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TICK_CNT_W       = 17;

   localparam int NUM_OUT  = 2;
   localparam int SRC_W    = 4;
   localparam int NUM_SRC  = 16;
   localparam int TIME_W   = 14;

   localparam logic [TIME_W-1:0] TIME_MAX = 14'h270F;
   localparam logic [TIME_W-1:0] TIME_RST = 14'h0000;
   localparam logic [15:0]       TIME_MAX_WIDE = 16'h270F;

   // assignment codes; codes above SRC_PRECHARGE pick plain information bits
   localparam logic [SRC_W-1:0] SRC_NONE      = 4'h0;
   localparam logic [SRC_W-1:0] SRC_NO_FAULT  = 4'h1;
   localparam logic [SRC_W-1:0] SRC_BRAKE     = 4'h2;
   localparam logic [SRC_W-1:0] SRC_LINE      = 4'h3;
   localparam logic [SRC_W-1:0] SRC_OUTPUT    = 4'h4;
   localparam logic [SRC_W-1:0] SRC_PRECHARGE = 4'h5;
   localparam logic [SRC_W-1:0] SRC_RST       = 4'h0;

   localparam logic POL_ACTIVE_HIGH = 1'b1;
   localparam logic POL_ACTIVE_LOW  = 1'b0;
   localparam logic POL_RST         = 1'b1;

   // byte addresses; each output owns a block of 32 bytes, selected by address bits 6:5
   localparam int             ADDR_W         = 7;
   localparam logic [4:0]     REG_ASSIGN     = 5'h00;
   localparam logic [4:0]     REG_ON_DELAY   = 5'h04;
   localparam logic [4:0]     REG_POLARITY   = 5'h08;
   localparam logic [4:0]     REG_HOLD_TIME  = 5'h0C;
   localparam logic [4:0]     REG_APP_ASSIGN = 5'h10;
   localparam logic [6:0]     REG_STATUS     = 7'h40;

   // status word fields
   localparam int ST_CARD_BIT  = 0;
   localparam int ST_PIN_LSB   = 1;
   localparam int ST_PEND_LSB  = 3;
   localparam int ST_LEVEL_LSB = 5;

   typedef enum logic [1:0] {
      TS_STEADY,
      TS_ON_WAIT,
      TS_OFF_WAIT
   } loc_tstate_e;

   function automatic logic locAppOnly(input logic [SRC_W-1:0] src);
      return (src == SRC_BRAKE) || (src == SRC_LINE) || (src == SRC_OUTPUT) || (src == SRC_PRECHARGE);
   endfunction : locAppOnly

   function automatic logic locDelayLocked(input logic [SRC_W-1:0] src);
      return (src == SRC_NO_FAULT) || locAppOnly(src);
   endfunction : locDelayLocked

   // output contactor keeps its settable holding time and polarity
   function automatic logic locHoldLocked(input logic [SRC_W-1:0] src);
      return locDelayLocked(src) && (src != SRC_OUTPUT);
   endfunction : locHoldLocked

   function automatic logic locPolLocked(input logic [SRC_W-1:0] src);
      return locHoldLocked(src);
   endfunction : locPolLocked

endpackage : loc_pkg

/* logic/loc_channel.sv */
`timescale 1ns/1ps
`default_nettype none

module loc_channel
   import loc_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   input  wire logic              tick,
   input  wire logic              info,
   input  wire logic [TIME_W-1:0] onDelay,
   input  wire logic [TIME_W-1:0] holdTime,
   input  wire logic              polHigh,
   output logic                   pinOut,
   output logic                   pending,
   output logic                   level
);

   loc_tstate_e       st_q,  st_d;
   logic [TIME_W-1:0] cnt_q, cnt_d;
   logic              lvl_q, lvl_d;
   logic              pin_q, pin_d;
   logic [TIME_W-1:0] cntInc;

   assign cntInc = cnt_q + 14'h0001;

   always_comb begin
      st_d  = st_q;
      cnt_d = cnt_q;
      lvl_d = lvl_q;
      unique case (st_q)
         TS_STEADY: begin
            cnt_d = TIME_RST;
            if (info && !lvl_q) begin
               if (onDelay == TIME_RST) begin
                  lvl_d = 1'b1;
               end else begin
                  st_d = TS_ON_WAIT; // [R2]
               end
            end else if (!info && lvl_q) begin
               if (holdTime == TIME_RST) begin
                  lvl_d = 1'b0;
               end else begin
                  st_d = TS_OFF_WAIT; // [R4]
               end
            end
         end
         TS_ON_WAIT: begin
            if (!info) begin
               st_d = TS_STEADY; // [R9]
            end else if (tick) begin
               // >= so a delay shortened while counting still ends
               if (cntInc >= onDelay) begin
                  lvl_d = 1'b1; // [R2] [R9]
                  st_d  = TS_STEADY;
               end else begin
                  cnt_d = cntInc;
               end
            end
         end
         TS_OFF_WAIT: begin
            if (info) begin
               st_d = TS_STEADY; // [R9]
            end else if (tick) begin
               if (cntInc >= holdTime) begin
                  lvl_d = 1'b0; // [R4] [R9]
                  st_d  = TS_STEADY;
               end else begin
                  cnt_d = cntInc;
               end
            end
         end
      endcase
      pin_d = polHigh ? lvl_d : ~lvl_d; // [R6]
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st_q  <= TS_STEADY;
         cnt_q <= TIME_RST;
         lvl_q <= 1'b0;
         pin_q <= 1'b0;
      end else begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
         lvl_q <= lvl_d;
         pin_q <= pin_d;
      end
   end

   assign pinOut  = pin_q;
   assign pending = (st_q != TS_STEADY);
   assign level   = lvl_q;

endmodule : loc_channel

`default_nettype wire

/* logic/loc_top.sv */
// Contract
// R1 - each output takes its source from a selectable assignment, and the brake, line, output and precharge contactor choices can only be set through the application-function assignment register.
// R2 - when the assigned information goes true the output changes only after the configured turn-on delay of 0 to 9999 ms, factory value 0.
// R3 - for no-fault, brake, output, precharge and line contactor assignments the turn-on delay is held at zero and cannot be set.
// R4 - when the assigned information goes false the output changes only after the configured holding time of 0 to 9999 ms, factory value 0.
// R5 - for no-fault, brake, precharge and line contactor assignments the holding time is held at zero, while the output contactor keeps a settable one.
// R6 - a per-output polarity selects whether the pin is 1 or 0 while the information is true, factory value active high.
// R7 - for no-fault, brake, precharge and line contactor assignments the polarity is locked to active high and a change is refused.
// R8 - the configuration of both outputs is reachable only while the extension card is fitted and is hidden otherwise.
// R9 - timers count in 1 ms ticks and a pending change is cancelled if the information reverts before it expires.
`timescale 1ns/1ps
`default_nettype none

module loc_top
   import loc_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYCLES_DFLT
) (
   input  wire logic               clk_sys,
   input  wire logic               rst_n,
   input  wire logic [ADDR_W-1:0]  avs_address,
   input  wire logic               avs_read,
   input  wire logic               avs_write,
   input  wire logic [31:0]        avs_writedata,
   input  wire logic [3:0]         avs_byteenable,
   output logic      [31:0]        avs_readdata,
   output logic                    avs_waitrequest,
   input  wire logic               cardFitted,
   input  wire logic [NUM_SRC-1:0] srcInfo,
   output logic                    logicOutputOne,
   output logic                    logicOutputTwo
);

   // card presence pin: two-flop synchroniser
   logic cardMeta_q, cardMeta_d;
   logic cardSync_q, cardSync_d;

   always_comb begin
      cardMeta_d = cardFitted;
      cardSync_d = cardMeta_q;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cardMeta_q <= 1'b0;
         cardSync_q <= 1'b0;
      end else begin
         cardMeta_q <= cardMeta_d;
         cardSync_q <= cardSync_d;
      end
   end

   // millisecond tick divider
   logic [TICK_CNT_W-1:0] tickCnt_q, tickCnt_d;
   logic                  tick_q,    tick_d;

   always_comb begin
      tick_d    = 1'b0;
      tickCnt_d = tickCnt_q + 17'h00001;
      if (tickCnt_q == TICK_CNT_W'(TICK_CYCLES - 1)) begin
         tickCnt_d = '0;
         tick_d    = 1'b1; // [R9]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         tickCnt_q <= '0;
         tick_q    <= 1'b0;
      end else begin
         tickCnt_q <= tickCnt_d;
         tick_q    <= tick_d;
      end
   end

   // bus handshake: every access takes one wait cycle, answer on the second
   logic        ack_q, ack_d;
   logic [31:0] rdata_q, rdata_d;
   logic        busReq;
   logic        wrFire;
   logic [15:0] wrMerged [NUM_OUT];

   assign busReq          = avs_read | avs_write;
   assign avs_waitrequest = busReq & ~ack_q;
   assign wrFire          = avs_write & ack_q;

   always_comb begin
      ack_d = busReq & ~ack_q;
   end

   // per-output configuration
   logic [SRC_W-1:0]  assign_q   [NUM_OUT];
   logic [SRC_W-1:0]  assign_d   [NUM_OUT];
   logic [TIME_W-1:0] onDelay_q  [NUM_OUT];
   logic [TIME_W-1:0] onDelay_d  [NUM_OUT];
   logic [TIME_W-1:0] holdTime_q [NUM_OUT];
   logic [TIME_W-1:0] holdTime_d [NUM_OUT];
   logic              pol_q      [NUM_OUT];
   logic              pol_d      [NUM_OUT];
   logic [31:0]       chRead     [NUM_OUT];
   logic              chHit      [NUM_OUT];
   logic [NUM_OUT-1:0] pinVec;
   logic [NUM_OUT-1:0] pendVec;
   logic [NUM_OUT-1:0] levelVec;

   function automatic logic [TIME_W-1:0] clampTime(input logic [15:0] val);
      // out-of-range writes saturate rather than wrap
      if (val > TIME_MAX_WIDE) begin
         return TIME_MAX;
      end
      return val[TIME_W-1:0];
   endfunction : clampTime

   genvar ch;
   generate
      for (ch = 0; ch < NUM_OUT; ch++) begin : g_out
         logic       sel;
         logic       wrAssign;
         logic       wrApp;
         logic       wrDelay;
         logic       wrHold;
         logic       wrPol;
         logic [SRC_W-1:0] newSrc;
         logic       info;

         assign sel = cardSync_q && (avs_address[6:5] == 2'(ch)); // [R8]

         // only the low two byte lanes hold any field
         assign wrMerged[ch] = {
            avs_byteenable[1] ? avs_writedata[15:8] : 8'h00,
            avs_byteenable[0] ? avs_writedata[7:0]  : 8'h00
         };

         assign wrAssign = wrFire && sel && (avs_address[4:0] == REG_ASSIGN);
         assign wrApp    = wrFire && sel && (avs_address[4:0] == REG_APP_ASSIGN);
         assign wrDelay  = wrFire && sel && (avs_address[4:0] == REG_ON_DELAY);
         assign wrHold   = wrFire && sel && (avs_address[4:0] == REG_HOLD_TIME);
         assign wrPol    = wrFire && sel && (avs_address[4:0] == REG_POLARITY);
         assign newSrc   = wrMerged[ch][SRC_W-1:0];

         always_comb begin
            assign_d[ch]   = assign_q[ch];
            onDelay_d[ch]  = onDelay_q[ch];
            holdTime_d[ch] = holdTime_q[ch];
            pol_d[ch]      = pol_q[ch];

            if (wrDelay && avs_byteenable[1:0] != 2'b00 && !locDelayLocked(assign_q[ch])) begin
               onDelay_d[ch] = clampTime(wrMerged[ch]); // [R2] [R3]
            end
            if (wrHold && avs_byteenable[1:0] != 2'b00 && !locHoldLocked(assign_q[ch])) begin
               holdTime_d[ch] = clampTime(wrMerged[ch]); // [R4] [R5]
            end
            if (wrPol && avs_byteenable[0] && !locPolLocked(assign_q[ch])) begin
               pol_d[ch] = wrMerged[ch][0]; // [R6] [R7]
            end

            // contactor codes through the plain register are refused
            if ((wrAssign && avs_byteenable[0] && !locAppOnly(newSrc)) ||
                (wrApp && avs_byteenable[0])) begin
               assign_d[ch] = newSrc; // [R1]
               if (locDelayLocked(newSrc)) begin
                  onDelay_d[ch] = TIME_RST; // [R3]
               end
               if (locHoldLocked(newSrc)) begin
                  holdTime_d[ch] = TIME_RST; // [R5]
               end
               if (locPolLocked(newSrc)) begin
                  pol_d[ch] = POL_ACTIVE_HIGH; // [R7]
               end
            end
         end

         always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
               assign_q[ch]   <= SRC_RST;
               onDelay_q[ch]  <= TIME_RST;
               holdTime_q[ch] <= TIME_RST;
               pol_q[ch]      <= POL_RST;
            end else begin
               assign_q[ch]   <= assign_d[ch];
               onDelay_q[ch]  <= onDelay_d[ch];
               holdTime_q[ch] <= holdTime_d[ch];
               pol_q[ch]      <= pol_d[ch];
            end
         end

         // code zero means no assignment and stays false
         assign info = (assign_q[ch] != SRC_NONE) && srcInfo[assign_q[ch]]; // [R1]

         loc_channel u_channel (
            .clk_sys  (clk_sys),
            .rst_n    (rst_n),
            .tick     (tick_q),
            .info     (info),
            .onDelay  (onDelay_q[ch]),
            .holdTime (holdTime_q[ch]),
            .polHigh  (pol_q[ch]),
            .pinOut   (pinVec[ch]),
            .pending  (pendVec[ch]),
            .level    (levelVec[ch])
         );

         always_comb begin
            chHit[ch]  = 1'b1;
            chRead[ch] = 32'h00000000;
            unique case (avs_address[4:0])
               REG_ASSIGN, REG_APP_ASSIGN: begin
                  chRead[ch][SRC_W-1:0] = assign_q[ch];
               end
               REG_ON_DELAY: begin
                  chRead[ch][TIME_W-1:0] = onDelay_q[ch];
               end
               REG_HOLD_TIME: begin
                  chRead[ch][TIME_W-1:0] = holdTime_q[ch];
               end
               REG_POLARITY: begin
                  chRead[ch][0] = pol_q[ch];
               end
               default: begin
                  chHit[ch] = 1'b0;
               end
            endcase
         end
      end
   endgenerate

   // read path: configuration hidden while the card is absent
   always_comb begin
      rdata_d = rdata_q;
      if (avs_read && !ack_q) begin
         rdata_d = 32'h00000000;
         if (avs_address == REG_STATUS) begin
            rdata_d[ST_CARD_BIT] = cardSync_q;
            rdata_d[ST_PIN_LSB +: NUM_OUT]   = pinVec;
            rdata_d[ST_PEND_LSB +: NUM_OUT]  = pendVec;
            rdata_d[ST_LEVEL_LSB +: NUM_OUT] = levelVec;
         end else if (cardSync_q && avs_address[6:5] == 2'b00 && chHit[0]) begin
            rdata_d = chRead[0]; // [R8]
         end else if (cardSync_q && avs_address[6:5] == 2'b01 && chHit[1]) begin
            rdata_d = chRead[1]; // [R8]
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h00000000;
      end else begin
         ack_q   <= ack_d;
         rdata_q <= rdata_d;
      end
   end

   assign avs_readdata   = rdata_q;
   assign logicOutputOne = pinVec[0];
   assign logicOutputTwo = pinVec[1];

endmodule : loc_top

`default_nettype wire

/* dv/loc_top_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module loc_checker
   import loc_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYCLES_DFLT
) (
   input wire logic               clk_sys,
   input wire logic               rst_n,
   input wire logic [ADDR_W-1:0]  avs_address,
   input wire logic               avs_read,
   input wire logic               avs_write,
   input wire logic [31:0]        avs_writedata,
   input wire logic [3:0]         avs_byteenable,
   input wire logic [31:0]        avs_readdata,
   input wire logic               avs_waitrequest,
   input wire logic               cardFitted,
   input wire logic [NUM_SRC-1:0] srcInfo,
   input wire logic               logicOutputOne,
   input wire logic               logicOutputTwo
);
   logic       rdAns;
   logic       cardPrev_q, cardPrev_d;
   logic [2:0] cardAge_q, cardAge_d;
   assign rdAns = avs_read && !avs_waitrequest;
   // card age only trusted past the two-flop synchroniser latency
   always_comb begin
      cardPrev_d = cardFitted;
      cardAge_d  = (cardFitted != cardPrev_q) ? 3'h0 : cardAge_q + {2'h0, cardAge_q != 3'h7};
   end
   always_ff @(posedge clk_sys) begin
      cardPrev_q <= rst_n ? cardPrev_d : 1'b0;
      cardAge_q  <= rst_n ? cardAge_d : 3'h0;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   property p_wait_one; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
   a_wait_one: assert property (p_wait_one) else $error("request waited more than one cycle");
   property p_idle; !(avs_read || avs_write) |-> !avs_waitrequest; endproperty
   a_idle: assert property (p_idle) else $error("waitrequest high while idle");
   property p_rst_pins; $rose(rst_n) |-> !logicOutputOne && !logicOutputTwo; endproperty
   a_rst_pins: assert property (p_rst_pins) else $error("pins not low after reset");
   property p_rd_stable; !avs_read |=> $stable(avs_readdata); endproperty
   a_rd_stable: assert property (p_rd_stable) else $error("read data moved without a read");
   property p_hidden; rdAns && !cardFitted && cardAge_q > 3'h4 && avs_address < 7'h40 |-> avs_readdata == 32'h0;
   endproperty
   a_hidden: assert property (p_hidden) else $error("config visible without card");
   property p_unmapped; rdAns && (avs_address inside {[7'h14:7'h1F], [7'h34:7'h3F], [7'h44:7'h7F]})
      |-> avs_readdata == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_st_card; rdAns && cardAge_q > 3'h4 && avs_address == REG_STATUS |-> avs_readdata[0] == cardFitted;
   endproperty
   a_st_card: assert property (p_st_card) else $error("status card bit wrong");
   property p_st_pins; rdAns && avs_address == REG_STATUS
      |-> avs_readdata[2:1] == {$past(logicOutputTwo), $past(logicOutputOne)}; endproperty
   a_st_pins: assert property (p_st_pins) else $error("status pin bits differ from pins");
   c_write: cover property (avs_write && !avs_waitrequest);
   c_rise: cover property ($rose(logicOutputOne));
   c_fall: cover property ($fell(logicOutputOne));
endmodule : loc_checker
bind loc_top loc_checker #(.TICK_CYCLES(TICK_CYCLES)) u_loc_checker (
   .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cardFitted(cardFitted),
   .srcInfo(srcInfo), .logicOutputOne(logicOutputOne), .logicOutputTwo(logicOutputTwo));
`default_nettype wire

/* dv/loc_load.sv */
`timescale 1ns/1ps
`default_nettype none
module loc_load #(
   parameter int PICKUP = 3
) (
   input  wire logic clk_sys,
   input  wire logic coil,
   output var logic  closed
);
   logic [7:0] age      = 8'h00;
   logic       closed_q = 1'b0;
   // armature only follows a coil level that has stood for PICKUP+1 cycles
   always_ff @(posedge clk_sys) begin
      age      <= (coil == closed_q) ? 8'h00 : age + 8'h01;
      closed_q <= (coil != closed_q && age >= 8'(PICKUP)) ? coil : closed_q;
   end
   assign closed = closed_q;
endmodule : loc_load
`default_nettype wire

/* dv/test_logic_output_conditioning.sv */
`timescale 1ns/1ps
`default_nettype none
module test_logic_output_conditioning
   import loc_pkg::*;
;
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic [6:0]  avs_address = 7'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'h3;
   logic [3:0]  beSel = 4'h3;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        cardFitted = 1'b1;
   logic [15:0] srcInfo = 16'h0;
   logic        pinOne, pinTwo, loadOne;
   logic [31:0] rnd = 32'h3DB3E18A;
   logic [31:0] tv;
   logic [63:0] expv;
   logic [63:0] expQ[$];
   int          nFail = 0;
   int          testsRun = 0;
   always #5 clk_sys = ~clk_sys;
   loc_top #(.TICK_CYCLES(10)) u_loc_top (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cardFitted(cardFitted),
      .srcInfo(srcInfo), .logicOutputOne(pinOne), .logicOutputTwo(pinTwo));
   loc_load #(.PICKUP(3)) u_loc_load (.clk_sys(clk_sys), .coil(pinOne), .closed(loadOne));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction : xs
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", testsRun, nFail);
      if (nFail == 0 && testsRun > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : conclude
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : cyc
   task automatic setSrc(input logic [15:0] v);
      @(posedge clk_sys);
      srcInfo <= v;
   endtask : setSrc
   // for reads d is the expected value, compared under mask m by the monitor
   task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d, input logic [31:0] m);
      if (!wr) expQ.push_back({m, d});
      @(posedge clk_sys);
      avs_address   <= a;
      avs_writedata <= d;
      avs_read      <= !wr;
      avs_write     <= wr;
      avs_byteenable <= beSel;
      // only the watchdog ends a wait that never answers
      do begin
         @(posedge clk_sys);
      end while (avs_waitrequest !== 1'b0);
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   always @(posedge clk_sys) begin
      if (rst_n && avs_read && avs_waitrequest === 1'b0) begin
         testsRun++;
         expv = expQ.pop_front();
         if ((avs_readdata & expv[63:32]) !== expv[31:0]) begin
            nFail++;
            $display("[FAIL] %0t addr %h got %h want %h", $time, avs_address, avs_readdata, expv[31:0]);
         end
      end
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      nFail++;
      conclude();
   end
   initial begin
      cyc(20);
      rst_n <= 1'b1;
      cyc(3);
      bus(0, 7'h00, 32'h0, 32'hF);
      bus(0, 7'h04, 32'h0, 32'h3FFF);
      bus(0, 7'h08, 32'h1, 32'h1);
      bus(0, 7'h0C, 32'h0, 32'h3FFF);
      bus(0, 7'h50, 32'h0, 32'hFFFFFFFF);
      for (int c = 2; c < 6; c++) begin
         bus(1, 7'h00, 32'(c), 32'h0);
         bus(0, 7'h00, 32'h0, 32'hF);
      end
      for (int c = 1; c < 6; c++) begin
         bus(1, 7'h10, 32'h0, 32'h0);
         bus(1, 7'h04, 32'h9, 32'h0);
         bus(1, 7'h0C, 32'h9, 32'h0);
         bus(1, 7'h08, 32'h0, 32'h0);
         bus(1, 7'h10, 32'(c), 32'h0);
         bus(1, 7'h04, 32'h5, 32'h0);
         bus(1, 7'h0C, 32'h5, 32'h0);
         bus(1, 7'h08, 32'h0, 32'h0);
         bus(0, 7'h00, 32'(c), 32'hF);
         bus(0, 7'h04, 32'h0, 32'h3FFF);
         bus(0, 7'h0C, (c == 4) ? 32'h5 : 32'h0, 32'h3FFF);
         bus(0, 7'h08, (c == 4) ? 32'h0 : 32'h1, 32'h1);
      end
      bus(1, 7'h10, 32'h0, 32'h0);
      bus(1, 7'h00, 32'h6, 32'h0);
      bus(1, 7'h04, 32'h3, 32'h0);
      bus(1, 7'h0C, 32'h2, 32'h0);
      bus(1, 7'h08, 32'h1, 32'h0);
      setSrc(16'h0040);
      cyc(12);
      bus(0, 7'h40, 32'h8, 32'hA);
      cyc(25);
      bus(0, 7'h40, 32'h2, 32'hA);
      setSrc(16'h0000);
      cyc(3);
      bus(0, 7'h40, 32'hA, 32'hA);
      setSrc(16'h0040);
      cyc(30);
      bus(0, 7'h40, 32'h2, 32'hA);
      testsRun++;
      if (loadOne !== 1'b1) begin
         nFail++;
         $display("[FAIL] %0t load not closed", $time);
      end
      setSrc(16'h0000);
      cyc(25);
      bus(0, 7'h40, 32'h0, 32'hA);
      bus(1, 7'h28, 32'h0, 32'h0);
      bus(0, 7'h40, 32'h4, 32'h44);
      @(posedge clk_sys);
      cardFitted <= 1'b0;
      cyc(5);
      bus(1, 7'h24, 32'h7, 32'h0);
      bus(0, 7'h00, 32'h0, 32'hF);
      bus(0, 7'h40, 32'h0, 32'h1);
      @(posedge clk_sys);
      cardFitted <= 1'b1;
      cyc(5);
      bus(0, 7'h24, 32'h0, 32'h3FFF);
      bus(1, 7'h28, 32'h1, 32'h0);
      bus(1, 7'h20, 32'h7, 32'h0);
      repeat (8) begin
         rnd = xs(rnd);
         setSrc(rnd[15:0]);
         tv = {16'h0, rnd[31:16]};
         bus(1, 7'h04, tv, 32'h0);
         bus(0, 7'h04, (tv > 32'h270F) ? 32'h270F : tv, 32'h3FFF);
         bus(0, 7'h40, {29'h0, rnd[7], 2'h0}, 32'h4);
         testsRun++;
         if (pinTwo !== rnd[7]) begin
            nFail++;
            $display("[FAIL] %0t output two pin wrong", $time);
         end
      end
      // lane 0 only: the upper time byte reads as zero
      beSel = 4'h1;
      bus(1, 7'h04, 32'h1234, 32'h0);
      // polarity needs lane 0, so this write is dropped
      beSel = 4'h2;
      bus(1, 7'h28, 32'h0, 32'h0);
      beSel = 4'h3;
      bus(0, 7'h04, 32'h34, 32'h3FFF);
      bus(0, 7'h28, 32'h1, 32'h1);
      @(posedge clk_sys);
      rst_n <= 1'b0;
      cyc(2);
      rst_n <= 1'b1;
      cyc(2);
      bus(0, 7'h04, 32'h0, 32'h3FFF);
      bus(0, 7'h00, 32'h0, 32'hF);
      conclude();
   end
endmodule : test_logic_output_conditioning
`default_nettype wire
